// ==== rtl/pixclk_consts.svh ====
// Constants for the pixel clock, sync and power control block.
// Behaviour
// RQ1 - Host programs loop divisor only within 221 to 4095.
// RQ2 - Oscillator output is divided by programmed divisor plus one.
// RQ3 - Divided clock is phase compared with sync; error steers oscillator.
// RQ4 - Two-bit band select picks one of four oscillator ranges.
// RQ5 - Three-bit pump select maps to eight drive currents, 50 to 1500 uA.
// RQ6 - Five-bit phase shifts sampling clock in 32 steps of 11.25 degrees.
// RQ7 - Sync output carries the same phase shift as sampling clock.
// RQ8 - While hold is asserted, reference is cut and oscillator free-runs.
// RQ9 - Without auto detect, host sets sync and hold polarity to match inputs.
// RQ10 - Full power if bit set and sync seen, seek if none, else down.
// RQ11 - Power-down bit overrides automatic activity-based power choice.
// RQ12 - Sync detect is OR of activity status bits 7, 4 and 1.
// RQ13 - Seek and down power only bus, detectors, slicer and bandgap.
// RQ14 - Data clock rising edge falls between output data transitions.
// RQ15 - Pipeline shows four sets before valid data; receiver discards them.
// RQ16 - Input sync polarity found; output polarity chosen by control bit 5.
// RQ17 - Sync output is aligned with data clock and data outputs; code changes sync on data clock rising edges, data on falling edges.
// RQ18 - Sync output stays active for programmed width in pixel clocks.
// RQ19 - With continuous sync, hold input is tied inactive.
// RQ20 - Reference sync lies between 15 and 110 kHz.
// RQ21 - Divisor bits 11:4 in first register, bits 3:0 in upper nibble of second.
// RQ22 - Band select in bits 7:6, pump current in bits 5:3 of loop config.
// RQ23 - Output polarity bit 0 gives active-high, 1 gives active-low.
// RQ24 - On hold release, phase comparison resumes and lock is reacquired.
`ifndef PIXCLK_CONSTS_SVH
`define PIXCLK_CONSTS_SVH
`define REG_DIV_HIGH     8'h01
`define REG_DIV_LOW      8'h02
`define REG_LOOP_CFG     8'h03
`define REG_PHASE        8'h04
`define REG_SYNC_WIDTH   8'h07
`define REG_SYNC_CTRL    8'h0e
`define REG_POWER_CTRL   8'h0f
`define REG_ACTIVITY     8'h14
`define RST_DIV_HIGH     8'h69
`define RST_DIV_LOW      8'hd0
`define RST_LOOP_CFG     8'h48
`define RST_PHASE        8'h80
`define RST_SYNC_WIDTH   8'h20
`define RST_SYNC_CTRL    8'h40
`define RST_POWER_CTRL   8'h02
`define BIT_OUT_POL      5
`define BIT_IN_POL       6
`define BIT_POL_OVR      7
`define BIT_HOLD_POL     3
`define BIT_PWR          1
`define PIPE_SETS        4
`define PHASE_STEPS      32
`endif

// ==== rtl/pixclk_pkg.sv ====
// Types shared by the pixel clock control block.
package pixclk_pkg;
   typedef enum logic [1:0] {
      PWR_DOWN = 2'b00,
      PWR_SEEK = 2'b01,
      PWR_FULL = 2'b11
   } power_state_t;
   typedef logic [7:0] reg8_t;
endpackage

// ==== rtl/pix_buffer.sv ====
// Two-entry valid/ready buffer carrying output data words.
`timescale 1ns/10ps
module pix_buffer
   import pixclk_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       in_valid_i,
   output logic            in_ready_o,
   input  wire logic [8:0] in_data_i,
   output logic            out_valid_o,
   input  wire logic       out_ready_i,
   output logic [8:0]      out_data_o
);
   logic [8:0] mem_ff [2];
   logic       wr_ptr_ff;
   logic       rd_ptr_ff;
   logic [1:0] count_ff;
   logic       push;
   logic       pop;

   assign in_ready_o  = (count_ff != 2'h2);
   assign out_valid_o = (count_ff != 2'h0);
   assign out_data_o  = mem_ff[rd_ptr_ff];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mem_ff[0] <= 9'h000;
         mem_ff[1] <= 9'h000;
      end else if (push) begin
         mem_ff[wr_ptr_ff] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_ff <= 1'b0;
         rd_ptr_ff <= 1'b0;
         count_ff  <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_ff <= ~wr_ptr_ff;
         end
         if (pop) begin
            rd_ptr_ff <= ~rd_ptr_ff;
         end
         count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
      end
   end

   no_overflow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      count_ff <= 2'h2) else $error("Buffer count exceeds two.");
endmodule

// ==== rtl/pixclk_ctrl.sv ====
// Pixel clock loop control, sync output conditioning and power state logic.
`timescale 1ns/10ps
`include "pixclk_consts.svh"
module pixclk_ctrl
   import pixclk_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_addr_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic [7:0]      reg_rdata_o,
   input  wire logic       hsync_i,
   input  wire logic       hold_i,
   input  wire logic       osc_tick_i,
   input  wire logic [7:0] activity_i,
   input  wire logic [7:0] pixel_i,
   output logic            pixel_valid_o,
   input  wire logic       pixel_ready_i,
   output logic [7:0]      pixel_o,
   output logic            sync_out_o,
   output logic            pixel_data_clock_o,
   output logic [11:0]     divisor_o,
   output logic [1:0]      oscillator_band_field_o,
   output logic [2:0]      pump_current_o,
   output logic [4:0]      phase_o,
   output logic            freq_up_o,
   output logic            freq_down_o,
   output logic            loop_held_o,
   output logic [1:0]      power_state_o,
   output logic            core_power_o,
   output logic            always_on_power_o
);
   reg8_t        div_high_ff;
   reg8_t        div_low_ff;
   reg8_t        loop_cfg_ff;
   reg8_t        phase_ff;
   reg8_t        sync_width_ff;
   reg8_t        sync_ctrl_ff;
   reg8_t        power_ctrl_ff;
   reg8_t        activity_ff;
   logic [11:0]  vco_cnt_ff;
   logic         hs_d_ff;
   logic         hs_pol_ff;
   logic [11:0]  hs_high_ff;
   logic [11:0]  hs_low_ff;
   logic         hs_act;
   logic         hs_act_pol;
   logic         hs_rise;
   logic         held;
   logic         div_wrap;
   logic [4:0]   phase_cnt_ff;
   logic         shift_pend_ff;
   logic         sync_pulse;
   logic [7:0]   width_cnt_ff;
   logic         sync_act_ff;
   logic         up_ff;
   logic         down_ff;
   logic         ref_armed_ff;
   logic [2:0]   flush_cnt_ff;
   logic         dclk_ff;
   logic         buf_in_ready;
   logic [8:0]   buf_out;
   power_state_t pwr_ff;
   power_state_t nxt_pwr;
   logic         sync_seen;

   // Register write address decode is shared by every register process.
   function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
      hit = reg_wr_i && (a == target);
   endfunction

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         div_high_ff   <= `RST_DIV_HIGH;
         div_low_ff    <= `RST_DIV_LOW;
         loop_cfg_ff   <= `RST_LOOP_CFG;
         phase_ff      <= `RST_PHASE;
         sync_width_ff <= `RST_SYNC_WIDTH;
         sync_ctrl_ff  <= `RST_SYNC_CTRL;
         power_ctrl_ff <= `RST_POWER_CTRL;
      end else begin
         if (hit(reg_addr_i, `REG_DIV_HIGH))
            div_high_ff <= reg_wdata_i;
         if (hit(reg_addr_i, `REG_DIV_LOW))
            div_low_ff <= {reg_wdata_i[7:4], 4'h0};
         if (hit(reg_addr_i, `REG_LOOP_CFG))
            loop_cfg_ff <= {reg_wdata_i[7:3], 3'h0};
         if (hit(reg_addr_i, `REG_PHASE))
            phase_ff <= {reg_wdata_i[7:3], 3'h0};
         if (hit(reg_addr_i, `REG_SYNC_WIDTH))
            sync_width_ff <= reg_wdata_i;
         if (hit(reg_addr_i, `REG_SYNC_CTRL))
            sync_ctrl_ff <= reg_wdata_i;
         if (hit(reg_addr_i, `REG_POWER_CTRL))
            power_ctrl_ff <= reg_wdata_i;
      end
   end

   // Activity bits are sticky; a write of one clears a bit, but a new event wins.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         activity_ff <= 8'h00;
      end else if (hit(reg_addr_i, `REG_ACTIVITY)) begin
         activity_ff <= (activity_ff & ~reg_wdata_i) | activity_i;
      end else begin
         activity_ff <= activity_ff | activity_i;
      end
   end

   always_comb begin
      case (reg_addr_i)
         `REG_DIV_HIGH:   reg_rdata_o = div_high_ff;
         `REG_DIV_LOW:    reg_rdata_o = div_low_ff;
         `REG_LOOP_CFG:   reg_rdata_o = loop_cfg_ff;
         `REG_PHASE:      reg_rdata_o = phase_ff;
         `REG_SYNC_WIDTH: reg_rdata_o = sync_width_ff;
         `REG_SYNC_CTRL:  reg_rdata_o = sync_ctrl_ff;
         `REG_POWER_CTRL: reg_rdata_o = power_ctrl_ff;
         `REG_ACTIVITY:   reg_rdata_o = activity_ff;
         default:         reg_rdata_o = 8'h00;
      endcase
      if (!reg_rd_i) begin
         reg_rdata_o = 8'h00;
      end
   end

   assign divisor_o               = {div_high_ff, div_low_ff[7:4]}; // RQ21
   assign oscillator_band_field_o = loop_cfg_ff[7:6]; // RQ4 RQ22
   assign pump_current_o          = loop_cfg_ff[5:3]; // RQ5 RQ22
   assign phase_o                 = phase_ff[7:3]; // RQ6

   // Polarity is learned from which level dominates a line, since sync is short.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hs_d_ff    <= 1'b0;
         hs_high_ff <= 12'h000;
         hs_low_ff  <= 12'h000;
         hs_pol_ff  <= 1'b1;
      end else begin
         hs_d_ff <= hsync_i;
         if (hsync_i && !hs_d_ff) begin
            hs_pol_ff  <= (hs_low_ff > hs_high_ff); // RQ16
            hs_high_ff <= 12'h000;
            hs_low_ff  <= 12'h000;
         end else if (hsync_i) begin
            hs_high_ff <= (hs_high_ff == 12'hfff) ? hs_high_ff : hs_high_ff + 12'h001;
         end else begin
            hs_low_ff <= (hs_low_ff == 12'hfff) ? hs_low_ff : hs_low_ff + 12'h001;
         end
      end
   end

   // The leading edge follows the effective polarity, learned or overridden.
   assign hs_act_pol = sync_ctrl_ff[`BIT_POL_OVR] ? sync_ctrl_ff[`BIT_IN_POL] : hs_pol_ff;
   assign hs_act     = (hsync_i == hs_act_pol); // RQ16
   assign hs_rise    = hs_act && (hs_d_ff != hs_act_pol);
   // Hold polarity bit chooses the asserted level of the hold input.
   assign held = (hold_i != sync_ctrl_ff[`BIT_HOLD_POL]); // RQ8 RQ19
   assign loop_held_o = held;

   assign div_wrap = osc_tick_i && (vco_cnt_ff == divisor_o);

   // Counter runs from 0 to the divisor, so the ratio is divisor plus one.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         vco_cnt_ff <= 12'h000;
      end else if (osc_tick_i) begin
         vco_cnt_ff <= div_wrap ? 12'h000 : vco_cnt_ff + 12'h001; // RQ2
      end
   end

   // Reference edge arms a window; the divided edge closes it. Early arrival means slow.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         up_ff        <= 1'b0;
         down_ff      <= 1'b0;
         ref_armed_ff <= 1'b0;
      end else if (held) begin
         up_ff        <= 1'b0; // RQ8
         down_ff      <= 1'b0;
         ref_armed_ff <= 1'b0; // RQ24
      end else begin
         up_ff   <= hs_rise && !div_wrap && !ref_armed_ff; // RQ3
         down_ff <= div_wrap && !hs_rise && ref_armed_ff; // RQ3
         if (hs_rise && !div_wrap) begin
            ref_armed_ff <= 1'b1;
         end else if (div_wrap) begin
            ref_armed_ff <= 1'b0;
         end
      end
   end
   assign freq_up_o   = up_ff;
   assign freq_down_o = down_ff;

   // Sync output is delayed by the phase setting in undivided oscillator ticks.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         phase_cnt_ff  <= 5'h00;
         shift_pend_ff <= 1'b0;
      end else if (hs_rise) begin
         phase_cnt_ff  <= phase_o; // RQ7
         shift_pend_ff <= 1'b1;
      end else if (shift_pend_ff && osc_tick_i) begin
         phase_cnt_ff  <= phase_cnt_ff - 5'h01;
         shift_pend_ff <= (phase_cnt_ff != 5'h00);
      end
   end
   assign sync_pulse = shift_pend_ff && osc_tick_i && (phase_cnt_ff == 5'h00);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         width_cnt_ff <= 8'h00;
         sync_act_ff  <= 1'b0;
      end else if (sync_pulse && (sync_width_ff != 8'h00)) begin
         width_cnt_ff <= sync_width_ff - 8'h01; // RQ18
         sync_act_ff  <= 1'b1;
      end else if (sync_act_ff && !dclk_ff) begin
         width_cnt_ff <= width_cnt_ff - 8'h01;
         sync_act_ff  <= (width_cnt_ff != 8'h00); // RQ18
      end
   end

   // Data clock toggles mid-cell; data words load on its falling edge, sync on its rising edge.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dclk_ff <= 1'b0;
      end else if (pwr_ff == PWR_FULL) begin
         dclk_ff <= ~dclk_ff; // RQ14
      end else begin
         dclk_ff <= 1'b0;
      end
   end
   assign pixel_data_clock_o = dclk_ff;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync_out_o <= 1'b0;
      end else if (!dclk_ff) begin
         sync_out_o <= sync_act_ff ^ sync_ctrl_ff[`BIT_OUT_POL]; // RQ16 RQ17 RQ23
      end
   end

   // Flush counter marks the first sets as invalid; tag bit travels with the word.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         flush_cnt_ff <= 3'h0;
      end else if (pwr_ff != PWR_FULL) begin
         flush_cnt_ff <= 3'h0;
      end else if (dclk_ff && buf_in_ready && (flush_cnt_ff != `PIPE_SETS)) begin
         flush_cnt_ff <= flush_cnt_ff + 3'h1; // RQ15
      end
   end

   pix_buffer u_buf (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .in_valid_i  (dclk_ff),
      .in_ready_o  (buf_in_ready),
      .in_data_i   ({flush_cnt_ff == `PIPE_SETS, pixel_i}),
      .out_valid_o (pixel_valid_o),
      .out_ready_i (pixel_ready_i),
      .out_data_o  (buf_out)
   );
   assign pixel_o = buf_out[7:0];

   assign sync_seen = activity_ff[7] | activity_ff[4] | activity_ff[1]; // RQ12

   always_comb begin
      case ({power_ctrl_ff[`BIT_PWR], sync_seen})
         2'b11:   nxt_pwr = PWR_FULL; // RQ10
         2'b10:   nxt_pwr = PWR_SEEK;
         default: nxt_pwr = PWR_DOWN; // RQ11
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pwr_ff <= PWR_SEEK;
      end else begin
         pwr_ff <= nxt_pwr;
      end
   end
   assign power_state_o     = pwr_ff;
   assign core_power_o      = (pwr_ff == PWR_FULL); // RQ13
   assign always_on_power_o = 1'b1; // RQ13

   power_override_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !power_ctrl_ff[`BIT_PWR] |=> pwr_ff == PWR_DOWN) else $error("Down bit ignored."); // RQ11
   power_full_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      power_ctrl_ff[`BIT_PWR] && sync_seen |=> pwr_ff == PWR_FULL)
      else $error("Full power missed."); // RQ10
   core_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      pwr_ff != PWR_FULL |=> !dclk_ff) else $error("Core clock ran unpowered."); // RQ13
   div_ratio_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      div_wrap |=> vco_cnt_ff == 12'h000) else $error("Divider wrap wrong."); // RQ2
   hold_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      held |=> !up_ff && !down_ff) else $error("Loop steered during hold."); // RQ8
   pol_sel_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !dclk_ff && !sync_act_ff |=> sync_out_o == $past(sync_ctrl_ff[`BIT_OUT_POL]))
      else $error("Idle sync level wrong."); // RQ23
   sync_edge_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      $changed(sync_out_o) |-> $past(!dclk_ff)) else $error("Sync not aligned."); // RQ17
   sync_det_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      activity_i[4] |=> sync_seen) else $error("Activity lost."); // RQ12
   dclk_run_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      pwr_ff == PWR_FULL ##1 pwr_ff == PWR_FULL |-> dclk_ff != $past(dclk_ff))
      else $error("Data clock stalled."); // RQ14
endmodule

// ==== verif/pixel_sink.sv ====
// Receiver model that latches words from the pixel output stream.
`timescale 1ns/10ps
module pixel_sink (
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       valid_i,
   input  wire logic [7:0] data_i,
   input  wire logic       stall_i,
   output logic            ready_o,
   output int              kept_o,
   output logic [7:0]      last_o
);
   int seen;
   // A stalled receiver withholds ready; after the first four, it keeps every word it takes.
   assign ready_o = !stall_i;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         seen <= 0;
         kept_o <= 0;
         last_o <= 8'h00;
      end else if (valid_i && ready_o) begin
         seen <= seen + 1;
         // The first words carry a stale pipeline and are thrown away.
         if (seen >= 4) begin
            kept_o <= kept_o + 1;
            last_o <= data_i;
         end
      end
   end
endmodule

// ==== verif/tb_pixel_clock_sync_power_control.sv ====
// Self-checking bench for the pixel clock, sync and power control block.
`timescale 1ns/10ps
module tb_pixel_clock_sync_power_control;
   import pixclk_pkg::*;
   logic        clk_i, rst_n_i, reg_wr_i, reg_rd_i, hsync_i, hold_i, osc_tick_i, stall;
   logic [7:0]  reg_addr_i, reg_wdata_i, activity_i, pixel_i, reg_rdata_o, pixel_o, last;
   logic        pixel_valid_o, pixel_ready_i, sync_out_o, pixel_data_clock_o;
   logic        freq_up_o, freq_down_o, loop_held_o, core_power_o, always_on_power_o;
   logic [11:0] divisor_o;
   logic [1:0]  oscillator_band_field_o, power_state_o;
   logic [2:0]  pump_current_o;
   logic [4:0]  phase_o;
   int          kept, mismatches, comparisons;

   pixclk_ctrl uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .hsync_i(hsync_i), .hold_i(hold_i),
      .osc_tick_i(osc_tick_i), .activity_i(activity_i), .pixel_i(pixel_i),
      .pixel_valid_o(pixel_valid_o), .pixel_ready_i(pixel_ready_i), .pixel_o(pixel_o),
      .sync_out_o(sync_out_o), .pixel_data_clock_o(pixel_data_clock_o),
      .divisor_o(divisor_o), .oscillator_band_field_o(oscillator_band_field_o),
      .pump_current_o(pump_current_o), .phase_o(phase_o), .freq_up_o(freq_up_o),
      .freq_down_o(freq_down_o), .loop_held_o(loop_held_o),
      .power_state_o(power_state_o), .core_power_o(core_power_o),
      .always_on_power_o(always_on_power_o));
   pixel_sink sink (.clk_i(clk_i), .rst_n_i(rst_n_i), .valid_i(pixel_valid_o),
      .data_i(pixel_o), .stall_i(stall), .ready_o(pixel_ready_i), .kept_o(kept),
      .last_o(last));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = !clk_i;
   end
   // Free-running source data and oscillator ticks keep the input paths busy.
   always @(posedge clk_i) begin
      #1 pixel_i = pixel_i + 8'h01;
      osc_tick_i = !osc_tick_i;
   end

   task automatic conclude();
      if (mismatches == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1 reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(posedge clk_i);
      #1 reg_wr_i = 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      #1 reg_rd_i = 1'b1;
      reg_addr_i = a;
      #20 chk($sformatf("reg %h", a), e, reg_rdata_o);
      reg_rd_i = 1'b0;
   endtask
   task automatic wait_pwr(input logic [1:0] e);
      int n;
      n = 0;
      while (power_state_o !== e && n < 8) begin
         @(posedge clk_i);
         #1 n++;
      end
      chk("power_state_o", e, power_state_o);
      if (power_state_o !== e) conclude();
   endtask
   task automatic pulse_act(input logic [7:0] v);
      @(posedge clk_i);
      #1 activity_i = v;
      @(posedge clk_i);
      #1 activity_i = 8'h00;
   endtask

   task automatic t_reset();
      rchk(8'h01, 8'h69);
      rchk(8'h02, 8'hd0);
      rchk(8'h03, 8'h48);
      rchk(8'h04, 8'h80);
      rchk(8'h07, 8'h20);
      rchk(8'h0e, 8'h40);
      rchk(8'h0f, 8'h02);
      rchk(8'h14, 8'h00);
      chk("divisor_o", 12'h69d, divisor_o);
      chk("power_state_o", 2'b01, power_state_o);
      chk("core_power_o", 1'b0, core_power_o);
      chk("always_on_power_o", 1'b1, always_on_power_o);
   endtask
   task automatic t_regs();
      wr(8'h01, 8'h0d);
      wr(8'h02, 8'hd7);
      chk("divisor_o min", 12'h0dd, divisor_o);
      rchk(8'h02, 8'hd0);
      wr(8'h01, 8'hff);
      wr(8'h02, 8'hf0);
      chk("divisor_o max", 12'hfff, divisor_o);
      wr(8'h04, 8'hff);
      chk("phase_o", 5'h1f, phase_o);
      rchk(8'h04, 8'hf8);
      wr(8'h30, 8'h5a);
      rchk(8'h30, 8'h00);
      for (int b = 0; b < 4; b++) begin
         for (int p = 0; p < 8; p++) begin
            wr(8'h03, {b[1:0], p[2:0], 3'b000});
            chk("oscillator_band_field_o", b[1:0], oscillator_band_field_o);
            chk("pump_current_o", p[2:0], pump_current_o);
         end
      end
      rchk(8'h03, 8'hf8);
   endtask
   task automatic t_power();
      logic [7:0] bits [3] = '{8'h80, 8'h10, 8'h02};
      foreach (bits[i]) begin
         pulse_act(bits[i]);
         wait_pwr(2'b11);
         chk("core_power_o full", 1'b1, core_power_o);
         rchk(8'h14, bits[i]);
         wr(8'h14, bits[i]);
         wait_pwr(2'b01);
      end
      pulse_act(8'h01);
      #600 chk("power_state_o seek", 2'b01, power_state_o);
      wr(8'h14, 8'h01);
      pulse_act(8'h80);
      wait_pwr(2'b11);
      wr(8'h0f, 8'h00);
      wait_pwr(2'b00);
      chk("core_power_o down", 1'b0, core_power_o);
      wr(8'h0f, 8'h02);
      wait_pwr(2'b11);
   endtask
   task automatic sync_pulse(input int w, input logic act, input string name);
      int n;
      n = 0;
      #2000 chk(name, !act, sync_out_o);
      @(posedge clk_i);
      #1 hsync_i = 1'b1;
      repeat (2) @(posedge clk_i);
      #1 hsync_i = 1'b0;
      repeat (40) begin
         @(posedge clk_i);
         #1 if (sync_out_o === act) n++;
      end
      // The width is counted in data clock periods, each two cycles long.
      comparisons++;
      if (n != 2 * w) begin
         mismatches++;
         $display("ERROR %s width expected %0d seen %0d", name, w, n);
      end
   endtask
   task automatic t_sync();
      wr(8'h04, 8'h00);
      wr(8'h07, 8'h03);
      sync_pulse(3, 1'b1, "sync_out_o high");
      wr(8'h0e, 8'h20);
      sync_pulse(3, 1'b0, "sync_out_o low");
      wr(8'h0e, 8'h40);
      wr(8'h07, 8'h00);
      sync_pulse(0, 1'b1, "sync_out_o none");
   endtask
   task automatic t_hold();
      logic a;
      int   f;
      f = 0;
      a = loop_held_o;
      @(posedge clk_i);
      #1 hold_i = !hold_i;
      #10 chk("loop_held_o toggle", 1'b1, a ^ loop_held_o);
      if (loop_held_o !== 1'b1) hold_i = !hold_i;
      repeat (60) begin
         @(posedge clk_i);
         #1 hsync_i = !hsync_i;
         if (freq_up_o === 1'b1 || freq_down_o === 1'b1) f++;
      end
      chk("steer pulses held", 16'h0000, f[15:0]);
      wr(8'h0e, 8'h48);
      chk("loop_held_o inverted", 1'b0, loop_held_o);
      wr(8'h0e, 8'h40);
      @(posedge clk_i);
      #1 hold_i = !hold_i;
      #10 chk("loop_held_o released", 1'b0, loop_held_o);
      f = 0;
      repeat (10) begin
         @(posedge clk_i);
         #1 hsync_i = !hsync_i;
         if (freq_up_o === 1'b1 || freq_down_o === 1'b1) f++;
      end
      chk("steer resumes", 1'b1, f > 0);
   endtask
   task automatic t_stream();
      int         k;
      int         n;
      logic [7:0] p;
      logic       d;
      repeat (40) @(posedge clk_i);
      #1 d = pixel_data_clock_o;
      @(posedge clk_i);
      #1 chk("pixel_data_clock_o", 1'b1, d ^ pixel_data_clock_o);
      chk("words kept", 1'b1, kept > 0);
      stall = 1'b1;
      repeat (10) @(posedge clk_i);
      #1 p = pixel_o;
      k = kept;
      repeat (10) @(posedge clk_i);
      #1 chk("pixel_valid_o stalled", 1'b1, pixel_valid_o);
      chk("pixel_o stalled", p, pixel_o);
      chk("kept stalled", k[15:0], kept[15:0]);
      stall = 1'b0;
      n = 0;
      while (kept == k && n < 10) begin
         @(posedge clk_i);
         #1 n++;
      end
      chk("first word after stall", p, last);
      if (kept == k) begin
         mismatches++;
         conclude();
      end
   endtask

   initial begin
      rst_n_i = 1'b0;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = 8'h00;
      reg_wdata_i = 8'h00;
      hsync_i = 1'b0;
      hold_i = 1'b0;
      osc_tick_i = 1'b0;
      activity_i = 8'h00;
      pixel_i = 8'h00;
      stall = 1'b0;
      mismatches = 0;
      comparisons = 0;
      repeat (16) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      t_reset();
      t_regs();
      t_power();
      t_sync();
      t_hold();
      t_stream();
      conclude();
   end
endmodule
